// ### ads_params.svh
// Register map, field positions, reset values and timing of the converter sequencer.
`ifndef ADS_PARAMS_SVH
`define ADS_PARAMS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define ADS_OFF_CTRL      8'h00
`define ADS_OFF_RESULT    8'h04
`define ADS_OFF_INJ       8'h08
`define ADS_OFF_STATUS    8'h0C
`define ADS_OFF_IRQ_STAT  8'h10
`define ADS_OFF_IRQ_MASK  8'h14
`define ADS_OFF_DIGIN     8'h18

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define ADS_F_MODE   1:0
`define ADS_F_CHAN   5:2
`define ADS_B_START  6
`define ADS_B_PROT   7
`define ADS_B_WFR    8
`define ADS_F_CTC    10:9
`define ADS_F_STC    12:11
`define ADS_B_INJ    13
`define ADS_F_INJCH  17:14
`define ADS_CTRL_RST   32'h0000_0000
`define ADS_CTRL_STORE 32'h0003_DFBF

// ---------------------------------------------------------------
// Interrupt status bits and reset values
// ---------------------------------------------------------------
`define ADS_I_DONE 0
`define ADS_I_OVR  1
`define ADS_I_INJ  2
`define ADS_IRQ_RST 3'h0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define ADS_CLK_NS     5
`define ADS_TCL_NS     20
`define ADS_TCL_CLKS   (`ADS_TCL_NS / `ADS_CLK_NS)
`define ADS_TCC_X24    24
`define ADS_TCC_X96    96
`define ADS_TCC_X48    48
`define ADS_CONV_TCC   14
`define ADS_SAMP_TSC   2
`define ADS_XFER_TCL   4
`define ADS_CAL_TCC    4
`define ADS_RCAL_NS    1600000
`define ADS_RCAL_CYCLES ((`ADS_RCAL_NS + `ADS_CLK_NS - 1) / `ADS_CLK_NS)

`endif

// ### ads_pkg.sv
// Types shared by the converter sequencer.
package ads_pkg;

  // ---------------------------------------------------------------
  // Sequencer states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    S_IDLE   = 5'h01,
    S_SAMPLE = 5'h02,
    S_CONV   = 5'h04,
    S_XFER   = 5'h08,
    S_CAL    = 5'h10
  } ads_state_type;

  // ---------------------------------------------------------------
  // Conversion modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    M_SINGLE      = 2'h0,
    M_SINGLE_CONT = 2'h1,
    M_SCAN        = 2'h2,
    M_SCAN_CONT   = 2'h3
  } ads_mode_type;

endpackage : ads_pkg

// ### ads_sequencer.sv
// Converter sequencer: Wishbone registers, conversion timing, modes and calibration.
`timescale 1ns/100ps
`include "ads_params.svh"
module ads_sequencer #(
  parameter int RST_CAL_CYCLES = `ADS_RCAL_CYCLES,  // Reset calibration length in clocks.
  parameter int RCW            = $clog2(RST_CAL_CYCLES + 1)
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Wishbone slave.
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Interrupt and status.
  output logic             irq,
  output logic             converter_busy_flag,
  // Analog multiplexer and converter core.
  output logic      [3:0]  core_channel,
  output logic             core_sample,
  output logic             core_convert,
  output logic             core_calibrate,
  input  wire logic [9:0]  core_result,
  // Analog pins seen as digital levels.
  input  wire logic [15:0] ain_pin
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------

  // Merge write data into a word under the byte enables.
  function automatic logic [31:0] ads_merge(logic [31:0] old, logic [31:0] din, logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = din[i*8 +: 8];
      end
    end
    return r;
  endfunction : ads_merge

  // Conversion clock period in system clocks; reserved code 01 falls back to 24 phases.
  function automatic logic [15:0] ads_tcc(logic [1:0] ctc);
    unique case (ctc)
      2'h2:    return 16'(`ADS_TCC_X96 * `ADS_TCL_CLKS);
      2'h3:    return 16'(`ADS_TCC_X48 * `ADS_TCL_CLKS);
      default: return 16'(`ADS_TCC_X24 * `ADS_TCL_CLKS);
    endcase
  endfunction : ads_tcc

  // Length in system clocks of one sequencer phase.
  function automatic logic [15:0] ads_len(ads_pkg::ads_state_type st, logic [1:0] ctc, logic [1:0] stc);
    logic [15:0] conversion_clock_period;
    conversion_clock_period = ads_tcc(ctc);
    unique case (st)
      ads_pkg::S_SAMPLE: return 16'(`ADS_SAMP_TSC * (conversion_clock_period << stc));
      ads_pkg::S_CONV:   return 16'(`ADS_CONV_TCC * conversion_clock_period);
      ads_pkg::S_XFER:   return 16'(`ADS_XFER_TCL * `ADS_TCL_CLKS);
      default:           return 16'(`ADS_CAL_TCC * conversion_clock_period);
    endcase
  endfunction : ads_len

  // Inputs claimed by the converter in the current mode.
  function automatic logic [15:0] ads_used(logic [1:0] mode, logic [3:0] ch);
    logic [15:0] one;
    one = 16'h0001 << ch;
    return mode[1] ? ((one << 1) - 16'h0001) : one;
  endfunction : ads_used

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ads_pkg::ads_state_type state, next_state;   // Sequencer phase.
  logic [31:0]    ctl, next_ctl;               // Control word.
  logic [15:0]    cnt, next_cnt;               // Phase down-counter.
  logic [15:0]    lcnt, next_lcnt;             // Conversion length, checked below.
  logic [RCW-1:0] rcal, next_rcal;             // Reset calibration remaining.
  logic [3:0]     ptr, next_ptr;               // Scan pointer.
  logic [3:0]     chan, next_chan;             // Channel under conversion.
  logic           run, next_run;               // Sequence active.
  logic           inj_pend, next_inj_pend;     // Injection requested.
  logic           inj_act, next_inj_act;       // Injection in flight.
  logic           unread, next_unread;         // Result not yet read.
  logic           parked, next_parked;         // Result waiting in temporary buffer.
  logic [13:0]    res, next_res;               // Channel and value.
  logic [13:0]    tmp, next_tmp;               // Temporary buffer.
  logic [13:0]    ires, next_ires;             // Injected result.
  logic [2:0]     ist, next_ist;               // Sticky interrupt status.
  logic [2:0]     imask, next_imask;           // Interrupt mask.
  logic [31:0]    next_dat;                    // Read data.
  logic           next_ack;                    // Bus acknowledge.
  logic           next_irq;                    // Interrupt output.
  logic           next_busy;                   // Busy output.
  logic           next_cal;                    // Calibrate output.
  logic [15:0]    pin_s1, pin_s2;              // Pin synchroniser.

  // Combinational helpers.
  logic        bus_req;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [31:0] merged;
  logic [2:0]  iset;
  logic [2:0]  iclr;
  logic        cont;
  logic        unread_eff;

  assign core_sample  = state[1];
  assign core_convert = state[2];
  assign core_channel = chan;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // Bus, registers and sequencer share one process because reads of the
  // result register steer the sequencer in the same cycle.
  always_comb begin
    next_state = state;
    next_ctl = ctl;
    next_cnt = cnt;
    next_rcal = rcal;
    next_ptr = ptr;
    next_chan = chan;
    next_run = run;
    next_inj_pend = inj_pend;
    next_inj_act = inj_act;
    next_unread = unread;
    next_parked = parked;
    next_res = res;
    next_tmp = tmp;
    next_ires = ires;
    next_imask = imask;
    next_lcnt = 16'h0000;
    iset = 3'h0;
    iclr = 3'h0;
    bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wr = bus_req & wb_we_i;
    rd = bus_req & ~wb_we_i;
    addr = {wb_adr_i[7:2], 2'h0};
    merged = ads_merge(ctl, wb_dat_i, wb_sel_i);
    cont = ctl[0];
    next_ack = bus_req;
    // Read data; unmapped addresses read as zero.
    unique case (addr)
      `ADS_OFF_CTRL:     next_dat = ctl;
      `ADS_OFF_RESULT:   next_dat = {16'h0, res[13:10], 2'h0, res[9:0]};
      `ADS_OFF_INJ:      next_dat = {16'h0, ires[13:10], 2'h0, ires[9:0]};
      `ADS_OFF_STATUS:   next_dat = {27'h0, inj_pend, parked, unread, (rcal != '0), converter_busy_flag};
      `ADS_OFF_IRQ_STAT: next_dat = {29'h0, ist};
      `ADS_OFF_IRQ_MASK: next_dat = {29'h0, imask};
      `ADS_OFF_DIGIN:    next_dat = {16'h0, pin_s2 & ~ads_used(ctl[`ADS_F_MODE], ctl[`ADS_F_CHAN])};
      default:           next_dat = 32'h0;
    endcase
    if (!rd) begin
      next_dat = wb_dat_o;
    end
    // Register writes; start and inject bits act once and are not stored.
    if (wr && addr == `ADS_OFF_CTRL) begin
      next_ctl = merged & `ADS_CTRL_STORE;
      if (merged[`ADS_B_START]) begin
        next_run = 1'b1;
        next_ptr = merged[`ADS_F_CHAN];
      end
      if (merged[`ADS_B_INJ] && run && cont) begin
        next_inj_pend = 1'b1;
      end
    end
    if (wr && addr == `ADS_OFF_IRQ_STAT) begin
      iclr = wb_sel_i[0] ? wb_dat_i[2:0] : 3'h0;
    end
    if (wr && addr == `ADS_OFF_IRQ_MASK && wb_sel_i[0]) begin
      next_imask = wb_dat_i[2:0];
    end
    // A read of the result frees it, and releases a parked result.
    unread_eff = unread;
    if (rd && addr == `ADS_OFF_RESULT) begin
      unread_eff = 1'b0;
      next_unread = 1'b0;
      if (parked) begin
        next_res = tmp;
        next_unread = 1'b1;
        next_parked = 1'b0;
      end
    end
    // Phase counter.
    if (cnt != 16'h0) begin
      next_cnt = cnt - 16'h0001;
    end
    unique case (state)
      ads_pkg::S_IDLE: begin
        // Calibration only counts while idle, so conversions stretch it.
        if (rcal != '0) begin
          next_rcal = rcal - 1'b1;
        end
        if (inj_pend) begin
          next_inj_act = 1'b1;
          next_chan = ctl[`ADS_F_INJCH];
          next_state = ads_pkg::S_SAMPLE;
        end else if (run && !parked && !(ctl[`ADS_B_PROT] && unread_eff)) begin
          next_chan = ctl[1] ? ptr : ctl[`ADS_F_CHAN];
          next_state = ads_pkg::S_SAMPLE;
        end
        next_cnt = ads_len(ads_pkg::S_SAMPLE, ctl[`ADS_F_CTC], ctl[`ADS_F_STC]) - 16'h0001;
      end
      ads_pkg::S_SAMPLE: begin
        next_lcnt = lcnt + 16'h0001;
        if (cnt == 16'h0) begin
          next_state = ads_pkg::S_CONV;
          next_cnt = ads_len(ads_pkg::S_CONV, ctl[`ADS_F_CTC], ctl[`ADS_F_STC]) - 16'h0001;
        end
      end
      ads_pkg::S_CONV: begin
        next_lcnt = lcnt + 16'h0001;
        if (cnt == 16'h0) begin
          next_state = ads_pkg::S_XFER;
          next_cnt = ads_len(ads_pkg::S_XFER, ctl[`ADS_F_CTC], ctl[`ADS_F_STC]) - 16'h0001;
        end
      end
      ads_pkg::S_XFER: begin
        next_lcnt = lcnt + 16'h0001;
        if (cnt == 16'h0) begin
          next_state = ads_pkg::S_CAL;
          next_cnt = ads_len(ads_pkg::S_CAL, ctl[`ADS_F_CTC], ctl[`ADS_F_STC]) - 16'h0001;
          if (inj_act) begin
            next_ires = {chan, core_result};
            next_inj_act = 1'b0;
            next_inj_pend = 1'b0;
            iset[`ADS_I_INJ] = 1'b1;
          end else begin
            iset[`ADS_I_DONE] = 1'b1;
            if (unread_eff && ctl[`ADS_B_WFR] && cont) begin
              next_tmp = {chan, core_result};
              next_parked = 1'b1;
            end else begin
              iset[`ADS_I_OVR] = unread_eff;
              next_res = {chan, core_result};
              next_unread = 1'b1;
            end
            // Advance the sequence after each stored result.
            unique case (ctl[`ADS_F_MODE])
              ads_pkg::M_SINGLE:      next_run = 1'b0;
              ads_pkg::M_SINGLE_CONT: next_run = 1'b1;
              ads_pkg::M_SCAN: begin
                next_run = (ptr != 4'h0);
                next_ptr = ptr - 4'h1;
              end
              ads_pkg::M_SCAN_CONT: begin
                next_ptr = (ptr == 4'h0) ? ctl[`ADS_F_CHAN] : ptr - 4'h1;
              end
            endcase
          end
        end
      end
      ads_pkg::S_CAL: begin
        if (cnt == 16'h0) begin
          next_state = ads_pkg::S_IDLE;
        end
      end
    endcase
    // Set wins over a clear in the same cycle.
    next_ist = (ist & ~iclr) | iset;
    next_irq = |(next_ist & next_imask);
    next_busy = (next_state != ads_pkg::S_IDLE) || (next_rcal != '0) || next_run || next_inj_pend;
    // Reset calibration pauses while a conversion runs, so the core is free to sample.
    next_cal = (next_state == ads_pkg::S_CAL) || ((next_rcal != '0) && (next_state == ads_pkg::S_IDLE));
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Synchronous reset; the reset calibration starts from its full length.
  always_ff @(posedge clk) begin
    pin_s1 <= ain_pin;
    pin_s2 <= pin_s1;
    if (!rst_b) begin
      state <= ads_pkg::S_IDLE;
      ctl <= `ADS_CTRL_RST;
      cnt <= 16'h0;
      lcnt <= 16'h0;
      rcal <= RCW'(RST_CAL_CYCLES);
      ptr <= 4'h0;
      chan <= 4'h0;
      run <= 1'b0;
      inj_pend <= 1'b0;
      inj_act <= 1'b0;
      unread <= 1'b0;
      parked <= 1'b0;
      res <= 14'h0;
      tmp <= 14'h0;
      ires <= 14'h0;
      ist <= `ADS_IRQ_RST;
      imask <= `ADS_IRQ_RST;
      wb_dat_o <= 32'h0;
      wb_ack_o <= 1'b0;
      irq <= 1'b0;
      converter_busy_flag <= 1'b1;
      core_calibrate <= 1'b1;
    end else begin
      state <= next_state;
      ctl <= next_ctl;
      cnt <= next_cnt;
      lcnt <= next_lcnt;
      rcal <= next_rcal;
      ptr <= next_ptr;
      chan <= next_chan;
      run <= next_run;
      inj_pend <= next_inj_pend;
      inj_act <= next_inj_act;
      unread <= next_unread;
      parked <= next_parked;
      res <= next_res;
      tmp <= next_tmp;
      ires <= next_ires;
      ist <= next_ist;
      imask <= next_imask;
      wb_dat_o <= next_dat;
      wb_ack_o <= next_ack;
      irq <= next_irq;
      converter_busy_flag <= next_busy;
      core_calibrate <= next_cal;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic xfer_end;
  assign xfer_end = (state == ads_pkg::S_XFER) && (cnt == 16'h0);

  property p_overrun;
    xfer_end && !inj_act && unread && !(rd && addr == `ADS_OFF_RESULT) && !(ctl[`ADS_B_WFR] && cont) |=> ist[`ADS_I_OVR];
  endproperty
  a_overrun: assert property (p_overrun) else $error("Overrun not flagged.");
  property p_protect;
    (state == ads_pkg::S_IDLE) && ctl[`ADS_B_PROT] && unread && !inj_pend && !rd |=> !core_sample;
  endproperty
  a_protect: assert property (p_protect) else $error("Conversion started over unread result.");
  property p_single;
    xfer_end && !inj_act && ctl[`ADS_F_MODE] == ads_pkg::M_SINGLE && !wr |=> !run ##1 !core_sample;
  endproperty
  a_single: assert property (p_single) else $error("Single mode did not stop.");
  property p_cont;
    xfer_end && !inj_act && ctl[`ADS_F_MODE] == ads_pkg::M_SINGLE_CONT |=> run;
  endproperty
  a_cont: assert property (p_cont) else $error("Continuous mode stopped.");
  property p_scan;
    xfer_end && !inj_act && ctl[1] && ptr != 4'h0 && !wr |=> ptr == $past(ptr) - 4'h1;
  endproperty
  a_scan: assert property (p_scan) else $error("Scan pointer did not step.");
  property p_park;
    parked && !(rd && addr == `ADS_OFF_RESULT) && !inj_pend |=> !core_sample && parked;
  endproperty
  a_park: assert property (p_park) else $error("Conversion ran while result parked.");
  property p_inject;
    xfer_end && inj_act |=> ires[9:0] == $past(core_result) && res == $past(res);
  endproperty
  a_inject: assert property (p_inject) else $error("Injected result misplaced.");
  property p_length;
    (state == ads_pkg::S_CAL) && ($past(state) == ads_pkg::S_XFER) && $stable(ctl) |->
      $past(lcnt) + 16'h0001 == ads_len(ads_pkg::S_SAMPLE, ctl[`ADS_F_CTC], ctl[`ADS_F_STC])
      + ads_len(ads_pkg::S_CONV, ctl[`ADS_F_CTC], ctl[`ADS_F_STC]) + 16'(`ADS_XFER_TCL * `ADS_TCL_CLKS);
  endproperty
  a_length: assert property (p_length) else $error("Conversion length wrong.");
  property p_rcal_hold;
    (rcal != '0) && (state != ads_pkg::S_IDLE) |=> rcal == $past(rcal) && converter_busy_flag;
  endproperty
  a_rcal_hold: assert property (p_rcal_hold) else $error("Reset calibration not held.");
  property p_cal_len;
    (state == ads_pkg::S_CAL) && ($past(state) == ads_pkg::S_XFER) |->
      cnt == ads_len(ads_pkg::S_CAL, $past(ctl[`ADS_F_CTC]), 2'h0) - 16'h0001;
  endproperty
  a_cal_len: assert property (p_cal_len) else $error("Calibration cycle length wrong.");
  property p_busy;
    (state != ads_pkg::S_IDLE) || (rcal != '0) |-> converter_busy_flag;
  endproperty
  a_busy: assert property (p_busy) else $error("Busy low while working.");

endmodule : ads_sequencer

// ### ads_core_model.sv
// Behavioural model of the analog multiplexer and converter core.
`timescale 1ns/100ps
module ads_core_model (
  // Clock.
  input  wire logic       clk,
  // Control from the sequencer.
  input  wire logic [3:0] core_channel,
  input  wire logic       core_sample,
  input  wire logic       core_convert,
  input  wire logic       core_calibrate,
  // Converted value.
  output logic      [9:0] core_result
);
  // ---------------------------------------------------------------
  // Result lines
  // ---------------------------------------------------------------
  logic [9:0] noise = 10'h155;  // Flips every cycle; driven out while no value is valid.

  // The churn makes a sequencer that samples too early read garbage.
  always @(posedge clk) begin
    noise <= ~noise;
  end

  // The value is a fixed code of the selected input, valid in transfer and in idle except during reset calibration.
  always_comb begin
    if (core_sample | core_convert | core_calibrate) begin
      core_result = noise;
    end else begin
      core_result = {core_channel, ~core_channel, 2'h2};
    end
  end
endmodule : ads_core_model

// ### adc_sequencer_control_bench.sv
// Self-checking bench for the converter sequencer.
`timescale 1ns/100ps
`include "ads_params.svh"
module adc_sequencer_control_bench;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  typedef struct {logic [3:0] ch; logic [1:0] ctc; logic [1:0] stc; int smp; int cnv; int cal;} ads_row_type;
  logic        clk = 1'b0;      // 200 MHz clock.
  logic        rst_b = 1'b0;    // Synchronous reset, active low.
  logic [7:0]  adr = 8'h00;     // Bus address.
  logic [31:0] wdat = 32'h0;    // Bus write data.
  logic [3:0]  sel = 4'hF;      // Byte enables, always whole words.
  logic        we = 1'b0;       // Bus direction.
  logic        cyc = 1'b0;      // Bus cycle.
  logic        stb = 1'b0;      // Bus strobe.
  logic [15:0] ain = 16'hA5C3;  // Digital levels on the analog pins.
  logic [31:0] rdat;            // Bus read data.
  logic        ack, irq, busy;  // Bus answer, interrupt and busy.
  logic [3:0]  ch;              // Channel under conversion.
  logic        smp, cnv, cal;   // Core phase levels.
  logic [9:0]  res;             // Core result.
  logic [31:0] q;               // Last read value.
  int          failures = 0;    // Mismatches.
  int          checks_done = 0; // Comparisons.
  int          n_smp, n_cnv, n_cal, n;
  // Tcc is 96, 384, 192 clocks for codes 00, 10, 11; sample is 2*tsc.
  ads_row_type rows [4] = '{'{4'h0, 2'h0, 2'h0, 192, 1344, 384}, '{4'h5, 2'h2, 2'h1, 1536, 5376, 1536},
                            '{4'hF, 2'h3, 2'h2, 1536, 2688, 768}, '{4'h9, 2'h0, 2'h3, 1536, 1344, 384}};

  always #2.5 clk = ~clk;

  // Phase lengths are counted here so each row can compare them.
  always @(posedge clk) begin
    if (smp === 1'b1) n_smp++;
    if (cnv === 1'b1) n_cnv++;
    if (cal === 1'b1) n_cal++;
  end

  // ---------------------------------------------------------------
  // Instances
  // ---------------------------------------------------------------
  ads_sequencer #(.RST_CAL_CYCLES(50)) ads_sequencer_i (.clk(clk), .rst_b(rst_b), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq(irq), .converter_busy_flag(busy), .core_channel(ch), .core_sample(smp),
    .core_convert(cnv), .core_calibrate(cal), .core_result(res), .ain_pin(ain));
  ads_core_model ads_core_model_i (.clk(clk), .core_channel(ch), .core_sample(smp), .core_convert(cnv),
    .core_calibrate(cal), .core_result(res));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] cw(logic [1:0] m, logic [3:0] c, logic s, logic p, logic w,
                                     logic [1:0] t, logic [1:0] sc, logic i, logic [3:0] ic);
    return {14'h0, ic, i, sc, t, w, p, s, c, m};
  endfunction : cw
  // Expected result word of one input, channel in bits 15:12.
  function automatic logic [31:0] rv(logic [3:0] c);
    return {16'h0, c, 2'h0, c, ~c, 2'h2};
  endfunction : rv
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One classic cycle; held until ack is sampled, read data taken at that edge.
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic wait_idle;
    n = 0;
    while (busy !== 1'b0 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    if (busy !== 1'b0) failures++;
  endtask : wait_idle
  // Waits for the first sample phase, then for the end of all work.
  task automatic run_wait;
    n = 0;
    while (smp !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (smp !== 1'b1) failures++;
    wait_idle;
  endtask : run_wait
  task automatic wait_stat(input int b);
    q = 32'h0;
    for (int k = 0; k < 3000 && q[b] !== 1'b1; k++) wb(`ADS_OFF_IRQ_STAT, 32'h0, 1'b0);
    if (q[b] !== 1'b1) failures++;
  endtask : wait_stat
  task automatic test_done;
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // Cuts a hang short well after the whole sequence should be over.
  initial begin
    repeat (80000) @(posedge clk);
    failures++;
    test_done;
  end

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    chk({28'h0, busy, cal, irq, ack}, 32'hC);
    rst_b <= 1'b1;
    wait_idle;
    chk(32'(n >= 50), 32'h1);
    wb(`ADS_OFF_CTRL, 32'h0, 1'b0);
    chk(q, `ADS_CTRL_RST);
    wb(`ADS_OFF_IRQ_MASK, 32'h0, 1'b0);
    chk(q, 32'(`ADS_IRQ_RST));
    // Ordinary cases: one single conversion per row, phase lengths and result.
    for (int r = 0; r < 4; r++) begin
      n_smp = 0;
      n_cnv = 0;
      n_cal = 0;
      wb(`ADS_OFF_CTRL, cw(ads_pkg::M_SINGLE, rows[r].ch, 1, 0, 0, rows[r].ctc, rows[r].stc, 0, 0), 1'b1);
      run_wait;
      chk(n_smp, rows[r].smp);
      chk(n_cnv, rows[r].cnv);
      chk(n_cal, rows[r].cal);
      wb(`ADS_OFF_RESULT, 32'h0, 1'b0);
      chk(q, rv(rows[r].ch));
    end
    // Pins of inputs that a scan from 3 claims read as zero, the others as levels.
    wb(`ADS_OFF_CTRL, cw(ads_pkg::M_SCAN, 4'h3, 0, 0, 0, 0, 0, 0, 0), 1'b1);
    wb(`ADS_OFF_DIGIN, 32'h0, 1'b0);
    chk(q, 32'h0000_A5C0);
    wb(8'h1C, 32'hFFFF_FFFF, 1'b1);
    wb(8'h1C, 32'h0, 1'b0);
    chk(q, 32'h0);
    // Two conversions without a read: done is masked, overrun is not.
    wb(`ADS_OFF_IRQ_MASK, 32'h2, 1'b1);
    wb(`ADS_OFF_IRQ_STAT, 32'h7, 1'b1);
    for (int k = 0; k < 2; k++) begin
      chk({31'h0, irq}, 32'h0);
      wb(`ADS_OFF_CTRL, cw(ads_pkg::M_SINGLE, 4'h6, 1, 0, 0, 0, 0, 0, 0), 1'b1);
      run_wait;
    end
    wb(`ADS_OFF_IRQ_STAT, 32'h0, 1'b0);
    chk(q & 32'h7, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wb(`ADS_OFF_IRQ_STAT, 32'h7, 1'b1);
    wb(`ADS_OFF_RESULT, 32'h0, 1'b0);
    chk({31'h0, irq}, 32'h0);
    // Protected scan from 2: the unread result must survive a full conversion time.
    wb(`ADS_OFF_IRQ_MASK, 32'h1, 1'b1);
    wb(`ADS_OFF_CTRL, cw(ads_pkg::M_SCAN, 4'h2, 1, 1, 0, 0, 0, 0, 0), 1'b1);
    for (int k = 2; k >= 0; k--) begin
      wait_stat(`ADS_I_DONE);
      chk({31'h0, irq}, 32'h1);
      wb(`ADS_OFF_IRQ_STAT, 32'h1, 1'b1);
      if (k == 2) repeat (2500) @(posedge clk);
      wb(`ADS_OFF_RESULT, 32'h0, 1'b0);
      chk(q, rv(k[3:0]));
    end
    wait_idle;
    chk({31'h0, busy}, 32'h0);
    // Scan continuous from 1 with wait-for-read: the second result parks until a read.
    wb(`ADS_OFF_CTRL, cw(ads_pkg::M_SCAN_CONT, 4'h1, 1, 0, 1, 0, 0, 0, 0), 1'b1);
    repeat (5000) @(posedge clk);
    wb(`ADS_OFF_STATUS, 32'h0, 1'b0);
    chk(q, 32'hD);
    wb(`ADS_OFF_RESULT, 32'h0, 1'b0);
    chk(q, rv(4'h1));
    wb(`ADS_OFF_RESULT, 32'h0, 1'b0);
    chk(q, rv(4'h0));
    // Single mode ends the run after the conversion in flight, which wrapped back to 1.
    wb(`ADS_OFF_CTRL, cw(ads_pkg::M_SINGLE, 4'h1, 0, 0, 0, 0, 0, 0, 0), 1'b1);
    wait_idle;
    wb(`ADS_OFF_RESULT, 32'h0, 1'b0);
    chk(q, rv(4'h1));
    // Continuous input 4 with an injected conversion of input 7 in between.
    wb(`ADS_OFF_CTRL, cw(ads_pkg::M_SINGLE_CONT, 4'h4, 1, 0, 0, 0, 0, 0, 0), 1'b1);
    wb(`ADS_OFF_CTRL, cw(ads_pkg::M_SINGLE_CONT, 4'h4, 0, 0, 0, 0, 0, 1, 4'h7), 1'b1);
    wait_stat(`ADS_I_INJ);
    wb(`ADS_OFF_INJ, 32'h0, 1'b0);
    chk(q, rv(4'h7));
    wb(`ADS_OFF_IRQ_STAT, 32'h7, 1'b1);
    wait_stat(`ADS_I_DONE);
    wb(`ADS_OFF_RESULT, 32'h0, 1'b0);
    chk(q, rv(4'h4));
    chk({31'h0, busy}, 32'h1);
    // A second reset in mid-run restarts calibration.
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk({29'h0, busy, cal, smp}, 32'h6);
    rst_b <= 1'b1;
    // A conversion asked for during calibration runs, and calibration waits for it.
    wb(`ADS_OFF_CTRL, cw(ads_pkg::M_SINGLE, 4'h1, 1, 0, 0, 0, 0, 0, 0), 1'b1);
    wait_idle;
    chk(32'(n >= 1970), 32'h1);
    wb(`ADS_OFF_RESULT, 32'h0, 1'b0);
    chk(q, rv(4'h1));
    test_done;
  end
endmodule : adc_sequencer_control_bench
